// file: common/ccr_pkg.sv
// Package: constants, layouts and helpers of the cell reassembler
package ccr_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] RX_FIFO_BASE_OFS = 16'h4020;
  localparam logic [15:0] RX_FIFO_WPTR_OFS = 16'h4022;
  localparam logic [15:0] RX_FIFO_BASE_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Cell geometry and counts
  // ----------------------------------------------------------------
  localparam logic [5:0] CELL_LAST = 6'h34;
  localparam logic [5:0] HDR_LEN = 6'h05;
  localparam logic [2:0] WORD_LAST = 3'h4;
  localparam logic [2:0] WORD_STATE = 3'h3;
  localparam int MAX_CHANNELS = 122;
  localparam int MAX_VCS = 1024;

  // ----------------------------------------------------------------
  // Control structure field positions
  // ----------------------------------------------------------------
  localparam int FIRST_LSB = 8;
  localparam int LAST_LSB = 0;
  localparam int MINL_LSB = 0;
  localparam int MAXL_LSB = 8;
  localparam int AVGL_LSB = 0;
  localparam int TYPE_LSB = 8;
  localparam int PSIZE_LSB = 10;
  localparam int CUR_LSB = 0;
  localparam int AAL1_LSB = 8;
  localparam int START_BIT = 15;
  localparam int SIZE_LSB = 12;
  localparam int VALID_BIT = 15;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    AAL_CBR0 = 2'h0,
    AAL_RSVD = 2'h1,
    AAL_ONE = 2'h2,
    AAL_SRTS = 2'h3
  } ccr_aal_type;

  typedef struct packed {
    logic sop;
    logic cbr;
    logic [16:0] sptr;
    logic [7:0] data;
  } ccr_cell_byte_type;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [9:0] lead_bytes(input logic [7:0] lead);
    lead_bytes = {lead, 2'b00};
  endfunction

  function automatic logic [9:0] size_mask(input logic [2:0] code);
    case (code)
      3'h0: size_mask = 10'h03f;
      3'h1: size_mask = 10'h07f;
      3'h2: size_mask = 10'h0ff;
      3'h3: size_mask = 10'h1ff;
      3'h4: size_mask = 10'h3ff;
      default: size_mask = 10'h03f;
    endcase
  endfunction

endpackage

// file: tb/cbr_cell_reassembly_tb.sv
// Self-checking bench of the cell reassembler
`timescale 1ns/1ps
module cbr_cell_reassembly_tb;
  import ccr_pkg::*;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cell_valid_i = 1'b0;
  logic cell_ready_o;
  ccr_cell_byte_type cell_i = '0;
  logic [9:0] tdm_rd_ptr_i = 10'h000;
  logic [15:0] reg_addr_i = 16'h0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic [15:0] reg_rdata_o, mem_wdata_o, mem_rdata_i, d;
  logic mem_req_o, mem_we_o, mem_word_o, mem_ack_i;
  logic [20:0] mem_addr_o;
  logic overrun_o, underrun_o, seq_err_o;
  int fail_count = 0;
  int compares = 0;
  int seed = 37204;
  int ov_n = 0;
  int un_n = 0;
  int sq_n = 0;
  logic [7:0] pay [53];

  always #25 sys_clk_i = ~sys_clk_i;
  always @(negedge sys_clk_i) begin
    if (overrun_o === 1'b1) ov_n <= ov_n + 1;
    if (underrun_o === 1'b1) un_n <= un_n + 1;
    if (seq_err_o === 1'b1) sq_n <= sq_n + 1;
  end

  ccr_reassembler #(.FIFO_CELLS(128)) u_ccr_reassembler (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .cell_valid_i(cell_valid_i),
    .cell_ready_o(cell_ready_o), .cell_i(cell_i),
    .tdm_rd_ptr_i(tdm_rd_ptr_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .mem_req_o(mem_req_o),
    .mem_we_o(mem_we_o), .mem_word_o(mem_word_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i),
    .overrun_o(overrun_o), .underrun_o(underrun_o),
    .seq_err_o(seq_err_o));

  ccr_mem_model u_ccr_mem_model (
    .sys_clk_i(sys_clk_i), .mem_req_i(mem_req_o), .mem_we_i(mem_we_o),
    .mem_word_i(mem_word_o), .mem_addr_i(mem_addr_o),
    .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i),
    .mem_ack_o(mem_ack_i));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("compares %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Ffffh marks a byte that was never written
  function automatic logic [15:0] peek(input int a);
    if (u_ccr_mem_model.mem.exists(a)) return {8'h00, u_ccr_mem_model.mem[a]};
    return 16'hffff;
  endfunction

  task automatic reg_access(input logic wr, input logic [15:0] a,
      input logic [15:0] w);
    @(negedge sys_clk_i);
    reg_addr_i = a;
    reg_wdata_i = w;
    reg_wr_i = wr;
    reg_rd_i = !wr;
    @(negedge sys_clk_i);
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    d = reg_rdata_o;
  endtask

  // Gaps only between bytes, never while a byte waits for room
  task automatic send_cell(input logic cbr, input logic [16:0] sptr);
    int i;
    logic held;
    i = 0;
    held = 1'b0;
    for (int n = 0; n < 53; n++) pay[n] = 8'($random(seed));
    while (i < 53) begin
      @(negedge sys_clk_i);
      if (!held && $random(seed) % 5 == 0) begin
        cell_valid_i = 1'b0;
      end else begin
        cell_valid_i = 1'b1;
        cell_i = {i == 0, cbr, sptr, pay[i]};
        #20;
        held = cell_ready_o !== 1'b1;
        if (!held) i++;
      end
    end
    @(negedge sys_clk_i);
    cell_valid_i = 1'b0;
  endtask

  task automatic settle;
    int q;
    q = 0;
    for (int n = 0; n < 4000 && q < 12; n++) begin
      @(negedge sys_clk_i);
      q = (mem_req_o === 1'b1) ? 0 : q + 1;
    end
    check(16'(q), 16'(12));
  endtask

  // Fresh structure at 1000h, buffers at 4000h and 8000h, two cells
  task automatic run_row(input logic [1:0] aal_t, input logic [5:0] ps,
      input logic [2:0] sz, input int n, input logic [1:0] vm, input int ld);
    int mask, k, b0, st, wp, rd, lead, a, ov0, un0, sq0, sn, se;
    logic [15:0] e, w3, w4;
    mask = (64 << sz) - 1;
    k = aal_t[1] ? ps : ps + 1;
    b0 = aal_t[1] ? 6 : 5;
    wp = 0;
    sn = 0;
    u_ccr_mem_model.put_word(32'h1000, {8'd8, 8'(7 + n)});
    u_ccr_mem_model.put_word(32'h1002, 16'h0801);
    u_ccr_mem_model.put_word(32'h1004, {ps, aal_t, 8'h04});
    u_ccr_mem_model.put_word(32'h1006, 16'h0008);
    u_ccr_mem_model.put_word(32'h1008, {1'b0, sz, 12'h000});
    u_ccr_mem_model.put_word(32'h1010, {vm[0], 15'h0100});
    u_ccr_mem_model.put_word(32'h1012, {vm[1], 15'h0200});
    for (int c = 0; c < 2; c++) begin
      rd = (c == 0) ? ($random(seed) & mask) : ((wp - ld) & mask);
      lead = (wp - rd) & mask;
      st = (c == 0 || lead > 32 || lead < 4) ? rd + 16 : wp;
      for (int i = 0; i < k; i++) begin
        a = ((i % n) ? 32'h8000 : 32'h4000) | ((st + i / n) & mask);
        u_ccr_mem_model.mem.delete(a);
      end
      @(negedge sys_clk_i);
      tdm_rd_ptr_i = 10'(rd);
      ov0 = ov_n;
      un0 = un_n;
      sq0 = sq_n;
      send_cell(1'b1, 17'h00100);
      settle();
      for (int i = 0; i < k; i++) begin
        a = ((i % n) ? 32'h8000 : 32'h4000) | ((st + i / n) & mask);
        e = vm[i % n] ? {8'h00, pay[b0 + i]} : 16'hffff;
        check(peek(a), e);
      end
      check(16'(ov_n - ov0), 16'(c == 1 && lead > 32));
      check(16'(un_n - un0), 16'(c == 1 && lead < 4));
      se = ((pay[5] >> 4) & 7) != (((sn >> 4) + 1) & 7);
      check(16'(sq_n - sq0), 16'(aal_t[1] && se));
      if (aal_t[1]) sn = pay[5];
      w3 = {8'(peek(32'h1007)), 8'(peek(32'h1006))};
      w4 = {8'(peek(32'h1009)), 8'(peek(32'h1008))};
      check({9'h000, w3[6:0]}, 16'h0008);
      check({8'h00, w3[15:8]}, 16'(sn));
      check({w4[15:12], 12'h000}, {1'b1, sz, 12'h000});
      wp = st + k / n;
      check(w4 & 16'(mask), 16'(wp & mask));
    end
    $display("test cbr row type %0d size %0d done", aal_t, sz);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    #4000000;
    fail_count++;
    complete_run();
  end

  initial begin
    repeat (12) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    rst_i = 1'b0;
    reg_access(1'b0, RX_FIFO_BASE_OFS, 16'h0000);
    check(d, RX_FIFO_BASE_RST);
    reg_access(1'b1, 16'h4024, 16'hffff);
    reg_access(1'b0, 16'h4024, 16'h0000);
    check(d, 16'h0000);
    reg_access(1'b1, RX_FIFO_BASE_OFS, 16'h0010);
    reg_access(1'b0, RX_FIFO_BASE_OFS, 16'h0000);
    check(d, 16'h0010);
    $display("test registers done");
    for (int c = 0; c < 2; c++) begin
      send_cell(1'b0, 17'($random(seed)));
      settle();
      for (int b = 0; b < 53; b++) begin
        check(peek(32'h20000 | (c << 6) | b), {8'h00, pay[b]});
      end
    end
    reg_access(1'b0, RX_FIFO_WPTR_OFS, 16'h0000);
    check(d, 16'h0002);
    $display("test data cells done");
    run_row(2'h0, 6'h2f, 3'h0, 1, 2'h1, 16);
    run_row(2'h2, 6'h2a, 3'h1, 2, 2'h3, 40);
    run_row(2'h3, 6'h10, 3'h2, 2, 2'h1, 2);
    run_row(2'h0, 6'h03, 3'h3, 2, 2'h3, 20);
    run_row(2'h1, 6'h07, 3'h4, 1, 2'h1, 33);
    complete_run();
  end
endmodule

// file: tb/ccr_mem_model.sv
// External memory controller model facing the reassembler
`timescale 1ns/1ps
module ccr_mem_model (
  input wire logic sys_clk_i,
  input wire logic mem_req_i,
  input wire logic mem_we_i,
  input wire logic mem_word_i,
  input wire logic [20:0] mem_addr_i,
  input wire logic [15:0] mem_wdata_i,
  output logic [15:0] mem_rdata_o,
  output logic mem_ack_o
);
  // ----------------------------------------------------------------
  // Storage, bytes kept sparse
  // ----------------------------------------------------------------
  logic [7:0] mem [int];
  int wait_n = 0;
  int turn = 0;

  initial begin
    mem_ack_o = 1'b0;
    mem_rdata_o = 16'h5a5a;
  end

  // Unwritten memory reads zero, as software clears reserved space
  function automatic logic [7:0] rd_byte(input int a);
    return mem.exists(a) ? mem[a] : 8'h00;
  endfunction

  task automatic put_word(input int a, input logic [15:0] w);
    mem[a] = w[7:0];
    mem[a + 1] = w[15:8];
  endtask

  // ----------------------------------------------------------------
  // Access: answer after 0 to 2 extra cycles, data scrambled between
  // ----------------------------------------------------------------
  always @(negedge sys_clk_i) begin
    if (mem_ack_o) begin
      mem_ack_o <= 1'b0;
      mem_rdata_o <= ~mem_rdata_o;
      wait_n <= turn % 3;
      turn <= turn + 1;
    end else if (mem_req_i === 1'b1) begin
      if (wait_n == 0) begin
        mem_ack_o <= 1'b1;
        if (mem_we_i) begin
          mem[int'(mem_addr_i)] = mem_wdata_i[7:0];
          if (mem_word_i) begin
            mem[int'(mem_addr_i) + 1] = mem_wdata_i[15:8];
          end
        end else begin
          mem_rdata_o <= {rd_byte(int'(mem_addr_i) + 1),
                          rd_byte(int'(mem_addr_i))};
        end
      end else begin
        wait_n <= wait_n - 1;
      end
    end else begin
      mem_rdata_o <= ~mem_rdata_o;
    end
  end
endmodule

// file: verilog/ccr_cell_buffer.sv
// Small valid/ready FIFO in front of the reassembler
`timescale 1ns/1ps
module ccr_cell_buffer #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 2
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready_o = (cnt_q != FULL);
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];

  always_comb begin
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_data_i;
      wr_d = (wr_q == PW'(DEPTH - 1)) ? '0 : PW'(wr_q + 1'b1);
    end
    if (pop) begin
      rd_d = (rd_q == PW'(DEPTH - 1)) ? '0 : PW'(rd_q + 1'b1);
    end
    if (push && !pop) begin
      cnt_d = CW'(cnt_q + 1'b1);
    end else if (pop && !push) begin
      cnt_d = CW'(cnt_q - 1'b1);
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      mem_q <= mem_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end
endmodule

// file: verilog/ccr_reassembler.sv
// Receive cell reassembler: CBR payload to circular buffers, data cells
// to the receive data cell FIFO
// Notes on behaviour
// (RULE1) CBR cell payload goes to timeslot buffers
// (RULE2) Non-CBR cells stored whole in data FIFO
// (RULE3) CBR-AAL5 handled as partially filled AAL0
// (RULE4) 1 to 122 channels, 1024 circuits
// (RULE5) Errors never halt; next cell proceeds
// (RULE6) Minimum lead times four is floor
// (RULE7) Maximum lead times four is ceiling
// (RULE8) Software sets average lead to midpoint
// (RULE9) Type code: 00 AAL0/5, 10/11 AAL1
// (RULE10) Payload size code sets bytes per cell
// (RULE11) Current entry starts at first, hardware advances
// (RULE12) Stored AAL1 byte checks sequence numbers
// (RULE13) Started flag set once structure has run
// (RULE14) First cell written at average lead
// (RULE15) Buffer size code 64 to 1024 bytes
// (RULE16) Stored write pointer marks next byte
// (RULE17) Write only to buffers marked valid
// (RULE18) Entry gives address bits 20 to 6
// (RULE19) Software aligns buffers to their size
// (RULE20) Software zeroes reserved structure fields
// (RULE21) Software builds structure before cells arrive
// (RULE22) Beyond maximum: overrun, restart at average
// (RULE23) Before minimum: underrun, restart at average
// (RULE24) Bytes spread first to last entry, wrap
`timescale 1ns/1ps
module ccr_reassembler #(
  parameter int FIFO_CELLS = 128
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic cell_valid_i,
  output logic cell_ready_o,
  input ccr_pkg::ccr_cell_byte_type cell_i,
  input wire logic [9:0] tdm_rd_ptr_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic mem_word_o,
  output logic [20:0] mem_addr_o,
  output logic [15:0] mem_wdata_o,
  input wire logic [15:0] mem_rdata_i,
  input wire logic mem_ack_i,
  output logic overrun_o,
  output logic underrun_o,
  output logic seq_err_o
);
  import ccr_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOAD = 3'b001,
    ST_CHECK = 3'b011,
    ST_STREAM = 3'b010,
    ST_ENTRY = 3'b110,
    ST_WRITE = 3'b111,
    ST_WBACK = 3'b101,
    ST_DATA = 3'b100
  } ccr_state_type;

  ccr_state_type state_q, state_d;
  logic [15:0] w_q [5];
  logic [15:0] w_d [5];
  logic [2:0] widx_q, widx_d;
  logic [5:0] pos_q, pos_d, remain_q, remain_d;
  logic [6:0] cur_q, cur_d, fifo_cnt_q, fifo_cnt_d;
  logic [9:0] wp_q, wp_d;
  logic [7:0] aal1_q, aal1_d;
  logic [15:0] ent_q, ent_d, fifo_base_q, fifo_base_d, rdata_q, rdata_d;
  logic [16:0] sptr_q, sptr_d;
  logic ovr_q, ovr_d, udr_q, udr_d, seq_q, seq_d;

  logic [26:0] bvec;
  ccr_cell_byte_type bdat;
  logic bvalid, bready, take, adv;
  logic [9:0] mask, lead, avgpos, off;
  logic [2:0] size_code;
  ccr_aal_type aal;
  logic [6:0] first_e, last_e;
  logic [2:0] seq_exp;

  // ----------------------------------------------------------------
  // Input buffer; a stall here reaches the cell source
  // ----------------------------------------------------------------
  ccr_cell_buffer #(
    .WIDTH($bits(ccr_cell_byte_type)),
    .DEPTH(2)
  ) u_buf (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .in_valid_i(cell_valid_i),
    .in_ready_o(cell_ready_o),
    .in_data_i(cell_i),
    .out_valid_o(bvalid),
    .out_ready_i(bready),
    .out_data_o(bvec)
  );
  assign bdat = ccr_cell_byte_type'(bvec);
  assign bready = take;

  // ----------------------------------------------------------------
  // Structure field decode
  // ----------------------------------------------------------------
  assign size_code = w_q[4][SIZE_LSB+:3];
  assign mask = size_mask(size_code); // [RULE15]
  assign aal = ccr_aal_type'(w_q[2][TYPE_LSB+:2]);
  assign first_e = w_q[0][FIRST_LSB+:7];
  assign last_e = w_q[0][LAST_LSB+:7];
  assign lead = (w_q[4][9:0] - tdm_rd_ptr_i) & mask;
  // Midpoint supplied by software, used as given
  assign avgpos = (tdm_rd_ptr_i + lead_bytes(w_q[2][AVGL_LSB+:8])) & mask;
  assign off = wp_q & mask;
  assign seq_exp = 3'(aal1_q[6:4] + 1'b1);

  // ----------------------------------------------------------------
  // Memory port
  // ----------------------------------------------------------------
  always_comb begin
    mem_req_o = 1'b0;
    mem_we_o = 1'b0;
    mem_word_o = 1'b1;
    mem_addr_o = {sptr_q, widx_q, 1'b0};
    mem_wdata_o = 16'h0000;
    unique case (state_q)
      ST_LOAD: mem_req_o = 1'b1;
      ST_ENTRY: begin
        mem_req_o = 1'b1;
        mem_addr_o = {sptr_q[16:4], cur_q, 1'b0}; // [RULE4]
      end
      ST_WRITE: begin
        mem_req_o = 1'b1;
        mem_we_o = 1'b1;
        mem_word_o = 1'b0;
        mem_addr_o = {ent_q[14:0], 6'h00} | {11'h000, off}; // [RULE18]
        mem_wdata_o = {8'h00, bdat.data};
      end
      ST_WBACK: begin
        mem_req_o = 1'b1;
        mem_we_o = 1'b1;
        if (widx_q == WORD_STATE) begin
          mem_wdata_o = {aal1_q, 1'b0, cur_q};
        end else begin
          mem_wdata_o = {1'b1, size_code, 2'b00, wp_q}; // [RULE13] [RULE16]
        end
      end
      ST_DATA: begin
        mem_req_o = bvalid;
        mem_we_o = 1'b1;
        mem_word_o = 1'b0;
        mem_addr_o = {fifo_base_q[7:0], fifo_cnt_q, pos_q}; // [RULE2]
        mem_wdata_o = {8'h00, bdat.data};
      end
      default: mem_req_o = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    w_d = w_q;
    widx_d = widx_q;
    pos_d = pos_q;
    remain_d = remain_q;
    cur_d = cur_q;
    wp_d = wp_q;
    aal1_d = aal1_q;
    ent_d = ent_q;
    sptr_d = sptr_q;
    fifo_cnt_d = fifo_cnt_q;
    ovr_d = 1'b0;
    udr_d = 1'b0;
    seq_d = 1'b0;
    take = 1'b0;
    adv = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        if (bvalid) begin
          if (!bdat.sop) begin
            take = 1'b1; // Stray bytes dropped, no lockup [RULE5]
          end else if (bdat.cbr) begin
            state_d = ST_LOAD; // [RULE1]
            sptr_d = bdat.sptr;
            widx_d = 3'h0;
          end else begin
            state_d = ST_DATA; // [RULE2]
          end
        end
      end
      ST_LOAD: begin
        if (mem_ack_i) begin
          w_d[widx_q] = mem_rdata_i;
          if (widx_q == WORD_LAST) begin
            state_d = ST_CHECK;
          end else begin
            widx_d = 3'(widx_q + 1'b1);
          end
        end
      end
      ST_CHECK: begin
        cur_d = w_q[3][CUR_LSB+:7]; // [RULE11]
        aal1_d = w_q[3][AAL1_LSB+:8]; // [RULE12]
        // Reserved type code falls back to AAL0 handling
        if (aal == AAL_ONE || aal == AAL_SRTS) begin // [RULE9]
          remain_d = w_q[2][PSIZE_LSB+:6]; // [RULE10]
        end else begin
          remain_d = 6'(w_q[2][PSIZE_LSB+:6] + 1'b1); // [RULE3] [RULE10]
        end
        if (!w_q[4][START_BIT]) begin
          wp_d = avgpos; // [RULE14]
        end else if (lead > lead_bytes(w_q[1][MAXL_LSB+:8])) begin // [RULE7]
          ovr_d = 1'b1; // [RULE22]
          wp_d = avgpos;
        end else if (lead < lead_bytes(w_q[1][MINL_LSB+:8])) begin // [RULE6]
          udr_d = 1'b1; // [RULE23]
          wp_d = avgpos;
        end else begin
          wp_d = w_q[4][9:0]; // [RULE16]
        end
        state_d = ST_STREAM;
      end
      ST_STREAM: begin
        if (bvalid) begin
          if (pos_q < HDR_LEN) begin
            take = 1'b1;
          end else if (pos_q == HDR_LEN && aal[1]) begin
            take = 1'b1;
            aal1_d = bdat.data;
            // Sequence slip reported, payload still used [RULE12] [RULE5]
            seq_d = (bdat.data[6:4] != seq_exp);
          end else if (remain_q != 6'h00) begin
            state_d = ST_ENTRY;
          end else begin
            take = 1'b1;
          end
        end
      end
      ST_ENTRY: begin
        if (mem_ack_i) begin
          ent_d = mem_rdata_i;
          if (mem_rdata_i[VALID_BIT]) begin
            state_d = ST_WRITE; // [RULE17]
          end else begin
            take = 1'b1;
            adv = 1'b1;
            state_d = ST_STREAM;
          end
        end
      end
      ST_WRITE: begin
        if (mem_ack_i) begin
          take = 1'b1; // [RULE1]
          adv = 1'b1;
          state_d = ST_STREAM;
        end
      end
      ST_WBACK: begin
        if (mem_ack_i) begin
          if (widx_q == WORD_LAST) begin
            state_d = ST_IDLE;
          end else begin
            widx_d = 3'(widx_q + 1'b1);
          end
        end
      end
      ST_DATA: begin
        take = bvalid && mem_ack_i;
      end
      default: state_d = ST_IDLE;
    endcase
    if (adv) begin
      remain_d = 6'(remain_q - 1'b1);
      if (cur_q == last_e) begin // [RULE24]
        cur_d = first_e;
        wp_d = (wp_q + 10'h001) & mask;
      end else begin
        cur_d = 7'(cur_q + 1'b1);
      end
    end
    if (take) begin
      pos_d = 6'(pos_q + 1'b1);
      if (state_q == ST_IDLE) begin
        pos_d = 6'h00;
      end else if (pos_q == CELL_LAST) begin
        pos_d = 6'h00;
        if (state_q == ST_DATA) begin
          state_d = ST_IDLE;
          fifo_cnt_d = (fifo_cnt_q == 7'(FIFO_CELLS - 1)) ? 7'h00 :
                       7'(fifo_cnt_q + 1'b1);
        end else begin
          state_d = ST_WBACK;
          widx_d = WORD_STATE;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_comb begin
    fifo_base_d = fifo_base_q;
    rdata_d = rdata_q;
    if (reg_wr_i && reg_addr_i == RX_FIFO_BASE_OFS) begin
      fifo_base_d = reg_wdata_i;
    end
    if (reg_rd_i) begin
      if (reg_addr_i == RX_FIFO_BASE_OFS) begin
        rdata_d = fifo_base_q;
      end else if (reg_addr_i == RX_FIFO_WPTR_OFS) begin
        rdata_d = {9'h000, fifo_cnt_q};
      end else begin
        rdata_d = 16'h0000;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      for (int i = 0; i < 5; i++) begin
        w_q[i] <= 16'h0000;
      end
      widx_q <= 3'h0;
      pos_q <= 6'h00;
      remain_q <= 6'h00;
      cur_q <= 7'h00;
      wp_q <= 10'h000;
      aal1_q <= 8'h00;
      ent_q <= 16'h0000;
      sptr_q <= 17'h00000;
      fifo_cnt_q <= 7'h00;
      fifo_base_q <= RX_FIFO_BASE_RST;
      rdata_q <= 16'h0000;
      ovr_q <= 1'b0;
      udr_q <= 1'b0;
      seq_q <= 1'b0;
    end else begin
      state_q <= state_d;
      w_q <= w_d;
      widx_q <= widx_d;
      pos_q <= pos_d;
      remain_q <= remain_d;
      cur_q <= cur_d;
      wp_q <= wp_d;
      aal1_q <= aal1_d;
      ent_q <= ent_d;
      sptr_q <= sptr_d;
      fifo_cnt_q <= fifo_cnt_d;
      fifo_base_q <= fifo_base_d;
      rdata_q <= rdata_d;
      ovr_q <= ovr_d;
      udr_q <= udr_d;
      seq_q <= seq_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign overrun_o = ovr_q;
  assign underrun_o = udr_q;
  assign seq_err_o = seq_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  idle_return_a: assert property ( // [RULE5]
    state_q == ST_WBACK && widx_q == WORD_LAST && mem_ack_i
    |=> state_q == ST_IDLE)
    else $error("reassembler did not return to idle");
  ovr_restart_a: assert property ( // [RULE22]
    overrun_o |-> !underrun_o && wp_q == $past(avgpos))
    else $error("overrun did not restart at average lead");
  udr_restart_a: assert property ( // [RULE23]
    underrun_o |-> !overrun_o && wp_q == $past(avgpos))
    else $error("underrun did not restart at average lead");
  first_avg_a: assert property ( // [RULE14]
    state_q == ST_CHECK && !w_q[4][START_BIT]
    |=> wp_q == $past(avgpos) && !overrun_o && !underrun_o)
    else $error("first cell not placed at average lead");
  valid_gate_a: assert property ( // [RULE17]
    state_q == ST_WRITE |-> ent_q[VALID_BIT])
    else $error("write to buffer not marked valid");
  byte_offset_a: assert property ( // [RULE18]
    state_q == ST_WRITE |-> mem_addr_o[5:0] == wp_q[5:0]
    && mem_addr_o[20:10] == ent_q[14:4])
    else $error("payload address badly formed");
  psize_count_a: assert property ( // [RULE10]
    state_q == ST_CHECK && aal == AAL_CBR0
    |=> remain_q == 6'($past(w_q[2][PSIZE_LSB+:6]) + 1'b1))
    else $error("AAL0 payload count wrong");
  started_set_a: assert property ( // [RULE13]
    state_q == ST_WBACK && widx_q == WORD_LAST |-> mem_wdata_o[START_BIT])
    else $error("started flag not written back");
  fifo_step_a: assert property ( // [RULE2]
    state_q == ST_DATA && take && pos_q == CELL_LAST
    |=> state_q == ST_IDLE && fifo_cnt_q != $past(fifo_cnt_q))
    else $error("data FIFO slot not advanced");
endmodule
